// ### cima_top.sv
// mask registers, fault and charger event flags, interrupt pulse and converter control
// assumes a register port with single-cycle write and read strobes, all inputs synchronous
// Overview of operation
// R1: power good toggle pulses unless blocked
// R2: thermistor change pulses unless bit 4 set
// R3: reverse mode toggle pulses unless bit 3
// R4: sync pin change pulses unless bit 1
// R5: tracking change to a non-zero state pulses unless bit 0
// R6: under-voltage event pulses unless bit 7
// R7: input over-voltage pulses unless bit 6
// R8: battery over-current pulses unless bit 5
// R9: battery over-voltage pulses unless bit 4
// R10: thermal shutdown pulses unless bit 3
// R11: timer expiry rising edge pulses unless bit 2
// R12: gate supply fault pulses unless bit 1
// R13: fault mask at 0x2A resets to zero
// R14: converter enable cleared by reset, watchdog
// R15: thermal compensation forces converter on
// R16: rate bit: zero continuous, one one-shot
// R17: speed field selects resolution, 11b reserved
// R18: averaging bit selects running average
// R19: seed bit picks existing or fresh start
// R20: one-shot completion pulses unless masked
// R21: event flags read-only, clear on read
// R22: masks suppress pulse only, flags set
// R23: reserved bits read zero, ignore writes
`include "cima_map.svh"
module cima_top
	import cima_pkg::*;
(
	input wire logic i_clk, // 250 MHz core clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_reg_reset, // register reset pulse
	input wire logic i_wdog_expired, // host-link watchdog expiry pulse
	input wire logic i_wr, // register write strobe
	input wire logic i_rd, // register read strobe
	input wire cima_pkg::cima_byte_t i_addr, // register address
	input wire cima_pkg::cima_byte_t i_wdata, // write data
	input wire logic i_done_irq_block, // conversion-complete mask from first mask register
	input wire logic i_conv_done, // one-shot conversion complete pulse
	input wire logic i_regulation_thermal_comp_on, // thermal compensation enable
	input wire logic i_input_power_good, // input power good status
	input wire logic [1:0] i_thermistor_state, // thermistor status
	input wire logic i_reverse_state, // reverse mode status
	input wire logic i_switching_sync_pin, // sync pin status
	input wire logic [1:0] i_power_tracking_state, // tracking status
	input wire logic i_input_undervolt, // under-voltage fault level
	input wire logic i_input_overvolt, // input over-voltage fault level
	input wire logic i_battery_overcurrent, // battery over-current fault level
	input wire logic i_battery_overvolt, // battery over-voltage fault level
	input wire logic i_thermal_trip, // thermal shutdown level
	input wire logic i_safety_timer_expired, // safety timer expired level
	input wire logic i_gate_drive_supply_fault, // gate supply fault level
	output cima_pkg::cima_byte_t o_rdata, // read data, registered
	output logic o_irq_pulse, // host interrupt pulse, one cycle
	output logic o_converter_run, // converter effectively enabled
	output logic o_one_shot, // one-shot mode selected
	output cima_pkg::cima_speed_t o_sample_speed, // resolution code
	output logic o_speed_reserved, // reserved speed code in use
	output logic o_averaging_on, // running average enabled
	output logic o_average_seed_select // seed from fresh conversion
);
	import cima_pkg::*;

	cima_byte_t chg_mask2;
	cima_byte_t fault_mask;
	cima_byte_t conv_ctrl;
	cima_byte_t chg_flag2;
	cima_byte_t fault_flag;
	logic pg_q;
	logic [1:0] ts_q;
	logic rev_q;
	logic sync_q;
	logic [1:0] mppt_q;
	logic uv_q;
	logic ov_q;
	logic oc_q;
	logic bov_q;
	logic trip_q;
	logic tmr_q;
	logic drv_q;
	logic rd_chg_flag;
	logic rd_fault_flag;
	logic wr_chg_mask;
	logic wr_fault_mask;
	logic wr_conv_ctrl;
	logic chg_irq_req;
	logic flt_irq_req;
	logic done_irq_req;
	logic next_irq;
	cima_byte_t chg_ev;
	cima_byte_t flt_ev;
	cima_byte_t next_rdata;
	logic clr_regs;

	function automatic cima_byte_t merge(input cima_byte_t old, input cima_byte_t wd,
		input cima_byte_t wm);
		merge = (old & ~wm) | (wd & wm);
	endfunction : merge

	// true when the strobe addresses the given register
	function automatic logic hit(input logic strobe, input cima_byte_t addr, input cima_byte_t ofs);
		hit = strobe && addr == ofs;
	endfunction : hit

	// level entered this cycle
	function automatic logic rise(input logic now, input logic prev);
		rise = now && !prev;
	endfunction : rise

	assign clr_regs = !i_rst_n || i_reg_reset;
	// flags clear on a read of their own address
	assign rd_chg_flag = hit(i_rd, i_addr, `CIMA_OFS_CHG_FLAG2);
	assign rd_fault_flag = hit(i_rd, i_addr, `CIMA_OFS_FAULT_FLAG);
	assign wr_chg_mask = hit(i_wr, i_addr, `CIMA_OFS_CHG_MASK2);
	assign wr_fault_mask = hit(i_wr, i_addr, `CIMA_OFS_FAULT_MASK);
	assign wr_conv_ctrl = hit(i_wr, i_addr, `CIMA_OFS_CONV_CTRL);

	always_comb
	begin
		chg_ev = 8'h00;
		flt_ev = 8'h00;
		// R1: power good toggle
		chg_ev[`CIMA_BIT_PG] = i_input_power_good ^ pg_q;
		// R2: thermistor change
		chg_ev[`CIMA_BIT_TS] = |(i_thermistor_state ^ ts_q);
		// R3: reverse toggle
		chg_ev[`CIMA_BIT_REV] = i_reverse_state ^ rev_q;
		// R4: sync change
		chg_ev[`CIMA_BIT_SYNC] = i_switching_sync_pin ^ sync_q;
		// R5: tracking change to a non-zero state
		chg_ev[`CIMA_BIT_MPPT] = |(i_power_tracking_state ^ mppt_q) && |i_power_tracking_state;
		// R6: under-voltage entry
		flt_ev[`CIMA_BIT_UV] = rise(i_input_undervolt, uv_q);
		// R7: over-voltage entry
		flt_ev[`CIMA_BIT_OV] = rise(i_input_overvolt, ov_q);
		// R8: over-current entry
		flt_ev[`CIMA_BIT_OCP] = rise(i_battery_overcurrent, oc_q);
		// R9: battery over-voltage entry
		flt_ev[`CIMA_BIT_BOV] = rise(i_battery_overvolt, bov_q);
		// R10: thermal trip entry
		flt_ev[`CIMA_BIT_THERMAL_TRIP] = rise(i_thermal_trip, trip_q);
		// R11: timer rising edge
		flt_ev[`CIMA_BIT_TMR] = rise(i_safety_timer_expired, tmr_q);
		// R12: gate supply fault
		flt_ev[`CIMA_BIT_DRV] = rise(i_gate_drive_supply_fault, drv_q);
	end

	// previous samples, one register per status input
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			pg_q <= 1'b0;
		else
			pg_q <= i_input_power_good;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			ts_q <= 2'h0;
		else
			ts_q <= i_thermistor_state;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			rev_q <= 1'b0;
		else
			rev_q <= i_reverse_state;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			sync_q <= 1'b0;
		else
			sync_q <= i_switching_sync_pin;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			mppt_q <= 2'h0;
		else
			mppt_q <= i_power_tracking_state;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			uv_q <= 1'b0;
		else
			uv_q <= i_input_undervolt;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			ov_q <= 1'b0;
		else
			ov_q <= i_input_overvolt;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			oc_q <= 1'b0;
		else
			oc_q <= i_battery_overcurrent;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			bov_q <= 1'b0;
		else
			bov_q <= i_battery_overvolt;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			trip_q <= 1'b0;
		else
			trip_q <= i_thermal_trip;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			tmr_q <= 1'b0;
		else
			tmr_q <= i_safety_timer_expired;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			drv_q <= 1'b0;
		else
			drv_q <= i_gate_drive_supply_fault;
	end

	// R23: reserved bits held zero
	always_ff @(posedge i_clk)
	begin
		if (clr_regs)
			chg_mask2 <= `CIMA_RST_CHG_MASK2;
		else if (wr_chg_mask)
			chg_mask2 <= merge(chg_mask2, i_wdata, `CIMA_WMASK_CHG_MASK2);
	end

	// R13: fault mask and reset
	always_ff @(posedge i_clk)
	begin
		if (clr_regs)
			fault_mask <= `CIMA_RST_FAULT_MASK;
		else if (wr_fault_mask)
			fault_mask <= merge(fault_mask, i_wdata, `CIMA_WMASK_FAULT_MASK);
	end

	always_ff @(posedge i_clk)
	begin
		if (clr_regs)
			conv_ctrl <= `CIMA_RST_CONV_CTRL;
		else
		begin
			if (wr_conv_ctrl)
				conv_ctrl <= merge(conv_ctrl, i_wdata, `CIMA_WMASK_CONV_CTRL);
			// R14: watchdog clears enable
			if (i_wdog_expired)
				conv_ctrl[`CIMA_BIT_CONV_EN] <= 1'b0;
		end
	end

	// R21: clear on read, set wins
	// R22: flags set regardless of mask
	always_ff @(posedge i_clk)
	begin
		if (clr_regs)
			chg_flag2 <= 8'h00;
		else
			chg_flag2 <= (rd_chg_flag ? 8'h00 : chg_flag2) | chg_ev;
	end

	always_ff @(posedge i_clk)
	begin
		if (clr_regs)
			fault_flag <= 8'h00;
		else
			fault_flag <= (rd_fault_flag ? 8'h00 : fault_flag) | flt_ev;
	end

	always_comb
	begin
		unique case (i_addr)
			`CIMA_OFS_CHG_FLAG2: next_rdata = chg_flag2;
			`CIMA_OFS_FAULT_FLAG: next_rdata = fault_flag;
			`CIMA_OFS_CHG_MASK2: next_rdata = chg_mask2;
			`CIMA_OFS_FAULT_MASK: next_rdata = fault_mask;
			`CIMA_OFS_CONV_CTRL: next_rdata = conv_ctrl;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= next_rdata;
	end

	// R1: R2: R3: R4: R5: charger events unless masked
	assign chg_irq_req = |(chg_ev & ~chg_mask2);
	// R6: R7: R8: R9: R10: R11: R12: faults unless masked
	assign flt_irq_req = |(flt_ev & ~fault_mask);
	// R20: one-shot completion pulse
	assign done_irq_req = i_conv_done && conv_ctrl[`CIMA_BIT_RATE] && !i_done_irq_block;
	assign next_irq = chg_irq_req || flt_irq_req || done_irq_req;

	always_ff @(posedge i_clk)
	begin
		if (clr_regs)
			o_irq_pulse <= 1'b0;
		else
			o_irq_pulse <= next_irq;
	end

	// R15: thermal compensation override
	assign o_converter_run = conv_ctrl[`CIMA_BIT_CONV_EN] || i_regulation_thermal_comp_on;
	// R16: conversion rate
	assign o_one_shot = conv_ctrl[`CIMA_BIT_RATE];
	// R17: sample speed
	assign o_sample_speed = conv_ctrl[`CIMA_BIT_SPD_LO +: 2];
	assign o_speed_reserved = o_sample_speed == `CIMA_SPD_RESERVED;
	// R18: averaging
	assign o_averaging_on = conv_ctrl[`CIMA_BIT_AVG];
	// R19: average seed
	assign o_average_seed_select = conv_ctrl[`CIMA_BIT_SEED];
endmodule : cima_top

// ### cima_map.svh
// register offsets, field positions and reset values of the mask and converter control bank
// assumes an 8-bit register port with byte addresses as printed
`ifndef CIMA_MAP_SVH
`define CIMA_MAP_SVH
`define CIMA_OFS_CHG_MASK2 8'h29
`define CIMA_OFS_FAULT_MASK 8'h2A
`define CIMA_OFS_CONV_CTRL 8'h2B
`define CIMA_OFS_CHG_FLAG2 8'h26
`define CIMA_OFS_FAULT_FLAG 8'h27
`define CIMA_RST_CHG_MASK2 8'h00
`define CIMA_RST_FAULT_MASK 8'h00
`define CIMA_RST_CONV_CTRL 8'h60
`define CIMA_WMASK_CHG_MASK2 8'h9B
`define CIMA_WMASK_FAULT_MASK 8'hFE
`define CIMA_WMASK_CONV_CTRL 8'hFC
`define CIMA_BIT_PG 7
`define CIMA_BIT_TS 4
`define CIMA_BIT_REV 3
`define CIMA_BIT_SYNC 1
`define CIMA_BIT_MPPT 0
`define CIMA_BIT_UV 7
`define CIMA_BIT_OV 6
`define CIMA_BIT_OCP 5
`define CIMA_BIT_BOV 4
`define CIMA_BIT_THERMAL_TRIP 3
`define CIMA_BIT_TMR 2
`define CIMA_BIT_DRV 1
`define CIMA_BIT_CONV_EN 7
`define CIMA_BIT_RATE 6
`define CIMA_BIT_SPD_LO 4
`define CIMA_BIT_AVG 3
`define CIMA_BIT_SEED 2
`define CIMA_SPD_RESERVED 2'h3
`endif

// ### cima_pkg.sv
// types shared by the mask and converter control bank
package cima_pkg;
	typedef logic [7:0] cima_byte_t;
	typedef logic [1:0] cima_speed_t;
endpackage : cima_pkg

// ### cima_top_asserts.sv
// checker for the mask and converter control bank
// assumes it is bound onto cima_top, one clock, synchronous active-low reset
module cima_top_asserts
	import cima_pkg::*;
(
	input wire logic i_clk, // clock
	input wire logic i_rst_n, // reset
	input wire logic i_reg_reset, // register reset
	input wire logic i_wdog_expired, // watchdog expiry
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	input wire cima_pkg::cima_byte_t i_addr, // address
	input wire cima_pkg::cima_byte_t i_wdata, // write data
	input wire logic i_regulation_thermal_comp_on, // thermal comp
	input wire logic i_input_undervolt, // under-voltage
	input wire logic i_safety_timer_expired, // timer expiry
	input wire cima_pkg::cima_byte_t o_rdata, // read data
	input wire logic o_irq_pulse, // interrupt pulse
	input wire logic o_converter_run, // converter run
	input wire logic o_one_shot, // one-shot mode
	input wire cima_pkg::cima_speed_t o_sample_speed // speed code
);
	import cima_pkg::*;
	cima_byte_t fm;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// shadow of the fault mask register
	always_ff @(posedge i_clk)
		if (!i_rst_n || i_reg_reset)
			fm <= 8'h00;
		else if (i_wr && i_addr == 8'h2A)
			fm <= i_wdata & 8'hFE;
	sequence s_run_write;
		i_wr && i_addr == 8'h2B && i_wdata[7] && !i_wdog_expired && !i_reg_reset;
	endsequence
	AST_UV_IRQ: assert property ($rose(i_input_undervolt) && !fm[7] && !i_reg_reset
		|=> o_irq_pulse)
		else $error("under-voltage rise gave no pulse");
	AST_TMR_IRQ: assert property ($rose(i_safety_timer_expired) && !fm[2] && !i_reg_reset
		|=> o_irq_pulse)
		else $error("timer expiry gave no pulse");
	AST_RUN_FORCE: assert property (i_regulation_thermal_comp_on |-> o_converter_run)
		else $error("converter not forced on");
	AST_RUN_WR: assert property (s_run_write |=> o_converter_run)
		else $error("converter enable write lost");
	AST_WDOG_CLR: assert property (i_wdog_expired
		|=> !o_converter_run || i_regulation_thermal_comp_on)
		else $error("watchdog did not clear enable");
	AST_RESET_CTRL: assert property (i_reg_reset |=> o_one_shot && o_sample_speed == 2'h2)
		else $error("control fields not reset");
	AST_MASK_RD: assert property (i_rd && i_addr == 8'h2A && !i_wr |=> o_rdata == fm)
		else $error("fault mask readback wrong");
	AST_UNMAPPED: assert property (i_rd && !(i_addr inside {[8'h26:8'h27], [8'h29:8'h2B]})
		|=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule : cima_top_asserts
bind cima_top cima_top_asserts chk_u (.i_clk, .i_rst_n, .i_reg_reset, .i_wdog_expired, .i_wr,
	.i_rd, .i_addr, .i_wdata, .i_regulation_thermal_comp_on, .i_input_undervolt,
	.i_safety_timer_expired, .o_rdata, .o_irq_pulse, .o_converter_run, .o_one_shot,
	.o_sample_speed);

// ### cima_host.sv
// host model on the register port of the bank
// assumes strobes taken at a rising edge and read data one cycle later
module cima_host
	import cima_pkg::*;
(
	input wire logic i_clk, // clock
	input wire cima_pkg::cima_byte_t i_rdata, // read data
	output logic o_wr = 1'b0, // write strobe
	output logic o_rd = 1'b0, // read strobe
	output cima_pkg::cima_byte_t o_addr = 8'h00, // address
	output cima_pkg::cima_byte_t o_wdata = 8'h00 // write data
);
	import cima_pkg::*;
	task automatic xfer(input bit w, input cima_byte_t a, input cima_byte_t d, output cima_byte_t q);
		@(posedge i_clk);
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		// released bus shows the inverse, never the last value
		o_addr <= ~a;
		o_wdata <= ~d;
		@(negedge i_clk);
		q = i_rdata;
	endtask : xfer
endmodule : cima_host

// ### tb_charger_irq_mask_adc_ctrl.sv
// self-checking bench for the mask and converter control bank
// assumes cima_host.sv as bus partner and the bound checker
module tb_charger_irq_mask_adc_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import cima_pkg::*;
	logic i_clk = 1'b0, i_rst_n = 1'b0, i_reg_reset = 1'b0, i_wdog_expired = 1'b0;
	logic i_done_irq_block = 1'b0, i_conv_done = 1'b0, i_regulation_thermal_comp_on = 1'b0;
	logic i_input_power_good = 1'b0, i_reverse_state = 1'b0, i_switching_sync_pin = 1'b0;
	logic [1:0] i_thermistor_state = 2'h0, i_power_tracking_state = 2'h0;
	logic [6:0] flt = 7'h00;
	logic i_wr, i_rd, o_irq_pulse, o_converter_run, o_one_shot, o_speed_reserved;
	logic o_averaging_on, o_average_seed_select;
	cima_byte_t i_addr, i_wdata, o_rdata, q, s;
	cima_speed_t o_sample_speed;
	cima_byte_t ra [3] = '{8'h29, 8'h2A, 8'h2B};
	cima_byte_t cb [5] = '{8'h80, 8'h10, 8'h08, 8'h02, 8'h01};
	int mdl [256];
	int fail_count = 0, n_compared = 0;
	cima_top dut_u (.i_clk, .i_rst_n, .i_reg_reset, .i_wdog_expired, .i_wr, .i_rd, .i_addr,
		.i_wdata, .i_done_irq_block, .i_conv_done, .i_regulation_thermal_comp_on,
		.i_input_power_good, .i_thermistor_state, .i_reverse_state, .i_switching_sync_pin,
		.i_power_tracking_state, .i_input_undervolt(flt[6]), .i_input_overvolt(flt[5]),
		.i_battery_overcurrent(flt[4]), .i_battery_overvolt(flt[3]), .i_thermal_trip(flt[2]),
		.i_safety_timer_expired(flt[1]), .i_gate_drive_supply_fault(flt[0]), .o_rdata,
		.o_irq_pulse, .o_converter_run, .o_one_shot, .o_sample_speed, .o_speed_reserved,
		.o_averaging_on, .o_average_seed_select);
	cima_host host_u (.i_clk, .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
		.o_wdata(i_wdata));
	initial
		forever #2 i_clk = ~i_clk;
	function automatic cima_byte_t lfsr(input cima_byte_t v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	task automatic chk(input string nm, input cima_byte_t seen, input cima_byte_t want);
		n_compared++;
		if (seen !== want)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
		end
	endtask : chk
	task automatic w(input cima_byte_t a, input cima_byte_t d);
		host_u.xfer(1'b1, a, d, q);
		mdl[a] = d & (a == 8'h29 ? 8'h9B : a == 8'h2A ? 8'hFE : a == 8'h2B ? 8'hFC : 8'h00);
	endtask : w
	task automatic r(input cima_byte_t a);
		host_u.xfer(1'b0, a, 8'h00, q);
		chk("rdata", q, mdl[a][7:0]);
	endtask : r
	task automatic ev(input int i, input bit m);
		cima_byte_t b;
		b = (i < 7) ? cima_byte_t'(8'h02 << i) : cb[i-7];
		w((i < 7) ? 8'h2A : 8'h29, m ? b : 8'h00);
		@(posedge i_clk);
		case (i)
			7: i_input_power_good <= ~i_input_power_good;
			8: i_thermistor_state <= i_thermistor_state + 2'h1;
			9: i_reverse_state <= ~i_reverse_state;
			10: i_switching_sync_pin <= ~i_switching_sync_pin;
			11: i_power_tracking_state <= i_power_tracking_state + 2'h1;
			default: flt[i] <= 1'b1;
		endcase
		@(posedge i_clk);
		@(negedge i_clk);
		chk("irq", o_irq_pulse, !m);
		@(posedge i_clk);
		flt <= 7'h00;
		@(negedge i_clk);
		chk("irq", o_irq_pulse, 8'h00);
		host_u.xfer(1'b0, (i < 7) ? 8'h27 : 8'h26, 8'h00, q);
		chk("flag", q, b);
		host_u.xfer(1'b0, (i < 7) ? 8'h27 : 8'h26, 8'h00, q);
		chk("flag", q, 8'h00);
	endtask : ev
	task automatic report_and_stop();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (20000) @(posedge i_clk);
		fail_count++;
		report_and_stop();
	end
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		mdl[8'h2B] = 8'h60;
		foreach (ra[k]) r(ra[k]);
		r(8'h55);
		foreach (ra[k]) w(ra[k], 8'hFF);
		foreach (ra[k]) r(ra[k]);
		@(posedge i_clk);
		i_reg_reset <= 1'b1;
		@(posedge i_clk);
		i_reg_reset <= 1'b0;
		foreach (ra[k]) mdl[ra[k]] = (k == 2) ? 8'h60 : 8'h00;
		foreach (ra[k]) r(ra[k]);
		for (int i = 0; i < 12; i++)
		begin
			ev(i, 1'b1);
			ev(i, 1'b0);
		end
		s = 8'h4D;
		repeat (24)
		begin
			s = lfsr(s);
			w(8'h2B, s);
			@(posedge i_clk);
			i_wdog_expired <= s[0];
			i_conv_done <= 1'b1;
			i_done_irq_block <= s[7] ^ s[1];
			i_regulation_thermal_comp_on <= s[1];
			@(posedge i_clk);
			i_wdog_expired <= 1'b0;
			i_conv_done <= 1'b0;
			@(negedge i_clk);
			if (s[0])
				mdl[8'h2B][7] = 1'b0;
			chk("run", o_converter_run, mdl[8'h2B][7] | s[1]);
			chk("irq", o_irq_pulse, s[6] & ~(s[7] ^ s[1]));
			chk("ctrl", {o_one_shot, o_sample_speed, o_averaging_on, o_average_seed_select},
				s[6:2]);
			chk("resv", o_speed_reserved, s[5] & s[4]);
			r(8'h2B);
		end
		report_and_stop();
	end
endmodule : tb_charger_irq_mask_adc_ctrl
